/* pms_consts.svh */
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

// ----------------------------------------
// clock and wake-up timing
// ----------------------------------------
`define PMS_CLK_PERIOD_NS 50
`define PMS_IDLE_WAKE_US 14
`define PMS_STBY_WAKE_US 151
`define PMS_SHDN_WAKE_US 1015
// longest times: integer division rounds down
`define PMS_IDLE_WAKE_CYC (`PMS_IDLE_WAKE_US * 1000 / `PMS_CLK_PERIOD_NS)
`define PMS_STBY_WAKE_CYC (`PMS_STBY_WAKE_US * 1000 / `PMS_CLK_PERIOD_NS)
`define PMS_SHDN_WAKE_CYC (`PMS_SHDN_WAKE_US * 1000 / `PMS_CLK_PERIOD_NS)
`define PMS_CNT_W 15

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define PMS_NUM_PADS 31
`define PMS_NUM_SRAM 4
`define PMS_PADS_RST 31'h0000_0000
`define PMS_SRAM_RST 4'h0

`endif

/* pms_pkg.sv */
package pms_pkg;

  typedef enum logic [4:0] {
    st_active  = 5'b0_0001,
    st_idle    = 5'b0_0010,
    st_standby = 5'b0_0100,
    st_shutdn  = 5'b0_1000,
    st_wake    = 5'b1_0000
  } pms_state_t;

  typedef enum logic [1:0] {
    mode_active  = 2'h0,
    mode_idle    = 2'h1,
    mode_standby = 2'h2,
    mode_shutdn  = 2'h3
  } pms_mode_t;

  typedef enum logic [1:0] {
    cause_none     = 2'h0,
    cause_por      = 2'h1,
    cause_pin      = 2'h2,
    cause_shdn_pin = 2'h3
  } pms_cause_t;

endpackage

/* pms_sync.sv */
`timescale 1ns/10ps

module pms_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;

  // a change counts once the second and third stages agree
  always_comb begin
    next_level = level;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_level[i] = s3[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end

endmodule

/* pms_sequencer.sv */
// Function
// - In active mode the core runs and enabled peripherals are clocked.
// - In idle mode peripheral clocks run while core and memory clocks stop.
// - Any interrupt in idle mode brings the device back to active.
// - In standby only the always-on domain keeps power.
// - Only a wake pin, a real-time-clock event or the reset pin ends standby.
// - Standby wake resumes the core without reset and keeps retained state.
// - All pads stay latched for the whole of standby.
// - Shutdown removes all power and holds pads at their entry values.
// - A level change on an enabled wake pin in shutdown wakes by reset.
// - The reset cause tells shutdown pin wake, reset pin and power-on apart.
// - Across shutdown only pad latches and nonvolatile memory survive.
// - The fast crystal reference is doubled to make the fast clock.
// - The slow internal oscillator is used when no slow crystal is fitted.
// - The core runs within 14 us of idle, 151.2 us of standby, 1015.2 us of off, counted from the wake input.
// - Software picks standby retention separately for each SRAM block.
`timescale 1ns/10ps
`include "pms_consts.svh"

module pms_sequencer #(
  parameter int unsigned SHDN_WAKE_CYC = `PMS_SHDN_WAKE_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sw_req_valid,
  input wire logic [1:0] sw_req_mode,
  input wire logic irq_pending,
  input wire logic rtc_event,
  input wire logic reset_pin_n,
  input wire logic [`PMS_NUM_PADS-1:0] wake_pin,
  input wire logic [`PMS_NUM_PADS-1:0] wake_pin_en,
  input wire logic [`PMS_NUM_PADS-1:0] gpio_out,
  input wire logic [`PMS_NUM_SRAM-1:0] sram_retain_cfg,
  input wire logic slow_xtal_present,
  output logic [4:0] power_state,
  output logic cpu_run,
  output logic cpu_clk_en,
  output logic mem_clk_en,
  output logic periph_clk_en,
  output logic main_power_en,
  output logic always_on_domain_en,
  output logic periph_retain,
  output logic [`PMS_NUM_SRAM-1:0] sram_retain,
  output logic pad_latch,
  output logic [`PMS_NUM_PADS-1:0] pad_out,
  output logic core_reset,
  output logic [1:0] reset_cause,
  output logic fast_clk_doubler_en,
  output logic slow_internal_oscillator_sel
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] ctl_level;
  logic [`PMS_NUM_PADS-1:0] pin_level;
  logic rtc_level;
  logic rst_pin_act;
  logic rtc_prev;
  logic rtc_rise;

  pms_sync #(.W(2)) u_ctl_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in({rtc_event, ~reset_pin_n}),
    .level(ctl_level)
  );

  pms_sync #(.W(`PMS_NUM_PADS)) u_pin_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(wake_pin),
    .level(pin_level)
  );

  assign rtc_level = ctl_level[1];
  assign rst_pin_act = ctl_level[0];
  assign rtc_rise = rtc_level & ~rtc_prev;

  // ----------------------------------------
  // mode state machine
  // ----------------------------------------
  pms_pkg::pms_state_t state;
  pms_pkg::pms_state_t next_state;
  logic [`PMS_CNT_W-1:0] wake_cnt;
  logic [`PMS_CNT_W-1:0] next_wake_cnt;
  logic wake_is_reset;
  logic next_wake_is_reset;
  pms_pkg::pms_cause_t cause;
  pms_pkg::pms_cause_t next_cause;
  logic [`PMS_NUM_PADS-1:0] pin_ref;
  logic [`PMS_NUM_PADS-1:0] next_pin_ref;
  logic pin_change;

  // enabled wake pins that moved away from the level seen at entry
  assign pin_change = |((pin_level ^ pin_ref) & wake_pin_en);

  always_comb begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    next_wake_is_reset = wake_is_reset;
    next_cause = cause;
    next_pin_ref = pin_ref;
    if (rst_pin_act) begin
      // reset pin wakes from every mode, shutdown included
      next_state = pms_pkg::st_wake;
      next_wake_cnt = `PMS_CNT_W'(SHDN_WAKE_CYC - 2);
      next_wake_is_reset = 1'b1;
      next_cause = pms_pkg::cause_pin;
    end else begin
      case (state)
        pms_pkg::st_active: begin
          next_pin_ref = pin_level;
          if (sw_req_valid) begin
            case (pms_pkg::pms_mode_t'(sw_req_mode))
              pms_pkg::mode_idle: next_state = pms_pkg::st_idle;
              pms_pkg::mode_standby: next_state = pms_pkg::st_standby;
              pms_pkg::mode_shutdn: next_state = pms_pkg::st_shutdn;
              default: next_state = pms_pkg::st_active;
            endcase
          end
        end
        pms_pkg::st_idle: begin
          if (irq_pending) begin
            next_state = pms_pkg::st_wake;
            next_wake_cnt = `PMS_CNT_W'(`PMS_IDLE_WAKE_CYC - 2);
            next_wake_is_reset = 1'b0;
          end
        end
        pms_pkg::st_standby: begin
          if (rtc_rise || pin_change) begin
            next_state = pms_pkg::st_wake;
            next_wake_cnt = `PMS_CNT_W'(`PMS_STBY_WAKE_CYC - 2);
            next_wake_is_reset = 1'b0;
          end
        end
        pms_pkg::st_shutdn: begin
          if (pin_change) begin
            next_state = pms_pkg::st_wake;
            next_wake_cnt = `PMS_CNT_W'(SHDN_WAKE_CYC - 2);
            next_wake_is_reset = 1'b1;
            next_cause = pms_pkg::cause_shdn_pin;
          end
        end
        pms_pkg::st_wake: begin
          if (wake_cnt == '0) begin
            next_state = pms_pkg::st_active;
            next_wake_is_reset = 1'b0;
          end else begin
            next_wake_cnt = wake_cnt - 1'b1;
          end
        end
        default: next_state = pms_pkg::st_wake;
      endcase
    end
  end

  // ----------------------------------------
  // outputs, decoded from the next state
  // ----------------------------------------
  logic next_cpu_clk_en;
  logic next_periph_clk_en;
  logic next_main_power_en;
  logic next_aon_en;
  logic next_pad_latch;
  logic [`PMS_NUM_PADS-1:0] next_pad_out;
  logic [`PMS_NUM_SRAM-1:0] next_sram_retain;
  logic next_periph_retain;
  logic next_core_reset;

  always_comb begin
    next_cpu_clk_en = (next_state == pms_pkg::st_active);
    next_periph_clk_en = (next_state == pms_pkg::st_active) ||
      (next_state == pms_pkg::st_idle);
    next_main_power_en = (next_state != pms_pkg::st_standby) &&
      (next_state != pms_pkg::st_shutdn);
    next_aon_en = (next_state != pms_pkg::st_shutdn);
    next_pad_latch = (next_state == pms_pkg::st_standby) ||
      (next_state == pms_pkg::st_shutdn) ||
      (pad_latch && next_wake_is_reset);
    // pads keep their last value while latched
    next_pad_out = pad_latch ? pad_out : gpio_out;
    if (next_pad_latch && next_state == pms_pkg::st_wake &&
        !next_wake_is_reset) begin
      next_pad_latch = 1'b0;
    end
    case (next_state)
      pms_pkg::st_standby: next_sram_retain = sram_retain_cfg;
      pms_pkg::st_shutdn: next_sram_retain = '0;
      default: next_sram_retain = {`PMS_NUM_SRAM{1'b1}};
    endcase
    // shutdown or reset wake drops peripheral state
    next_periph_retain = (next_state != pms_pkg::st_shutdn) &&
      !next_wake_is_reset;
    next_core_reset = next_wake_is_reset;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= pms_pkg::st_wake;
      wake_cnt <= `PMS_CNT_W'(SHDN_WAKE_CYC - 2);
      wake_is_reset <= 1'b1;
      cause <= pms_pkg::cause_por;
      pin_ref <= `PMS_PADS_RST;
      rtc_prev <= 1'b0;
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      main_power_en <= 1'b1;
      always_on_domain_en <= 1'b1;
      pad_latch <= 1'b0;
      pad_out <= `PMS_PADS_RST;
      sram_retain <= `PMS_SRAM_RST;
      periph_retain <= 1'b0;
      core_reset <= 1'b1;
      fast_clk_doubler_en <= 1'b1;
      slow_internal_oscillator_sel <= 1'b1;
    end else begin
      state <= next_state;
      wake_cnt <= next_wake_cnt;
      wake_is_reset <= next_wake_is_reset;
      cause <= next_cause;
      pin_ref <= next_pin_ref;
      rtc_prev <= rtc_level;
      cpu_clk_en <= next_cpu_clk_en;
      periph_clk_en <= next_periph_clk_en;
      main_power_en <= next_main_power_en;
      always_on_domain_en <= next_aon_en;
      pad_latch <= next_pad_latch;
      pad_out <= next_pad_out;
      sram_retain <= next_sram_retain;
      periph_retain <= next_periph_retain;
      core_reset <= next_core_reset;
      fast_clk_doubler_en <= next_main_power_en;
      slow_internal_oscillator_sel <= ~slow_xtal_present;
    end
  end

  assign power_state = state;
  assign cpu_run = cpu_clk_en;
  assign mem_clk_en = cpu_clk_en;
  assign reset_cause = cause;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_idle_irq;
    state == pms_pkg::st_idle && irq_pending && !rst_pin_act;
  endsequence

  sequence s_resumed;
    cpu_run || rst_pin_act;
  endsequence

  property p_idle_clocks;
    state == pms_pkg::st_idle |-> !cpu_clk_en && !mem_clk_en && periph_clk_en;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks)
    else $error("idle clock gating wrong");

  property p_idle_wake;
    s_idle_irq |=> state == pms_pkg::st_wake && !core_reset;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("interrupt did not leave idle");

  property p_idle_time;
    s_idle_irq |-> ##[1:280] s_resumed;
  endproperty
  a_idle_time: assert property (p_idle_time)
    else $error("idle wake took too long");

  property p_standby_power;
    state == pms_pkg::st_standby |-> always_on_domain_en && !main_power_en;
  endproperty
  a_standby_power: assert property (p_standby_power)
    else $error("standby power domains wrong");

  property p_standby_hold;
    state == pms_pkg::st_standby && !rtc_rise && !pin_change && !rst_pin_act
      |=> state == pms_pkg::st_standby;
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("standby left without wake event");

  property p_pad_stable;
    state == pms_pkg::st_standby && $past(state) == pms_pkg::st_standby
      |-> $stable(pad_out);
  endproperty
  a_pad_stable: assert property (p_pad_stable)
    else $error("pad changed during standby");

  property p_shdn_off;
    state == pms_pkg::st_shutdn |-> !always_on_domain_en && sram_retain == '0;
  endproperty
  a_shdn_off: assert property (p_shdn_off)
    else $error("shutdown left power on");

  property p_shdn_reset;
    state == pms_pkg::st_shutdn && pin_change && !rst_pin_act
      |=> core_reset && reset_cause == pms_pkg::cause_shdn_pin;
  endproperty
  a_shdn_reset: assert property (p_shdn_reset)
    else $error("shutdown pin wake not a reset");

  property p_no_self_sleep;
    state == pms_pkg::st_active && !sw_req_valid |=>
      state == pms_pkg::st_active || state == pms_pkg::st_wake;
  endproperty
  a_no_self_sleep: assert property (p_no_self_sleep)
    else $error("low-power mode entered unrequested");

  property p_cause_stable;
    !rst_pin_act && !(state == pms_pkg::st_shutdn && pin_change)
      |=> $stable(reset_cause);
  endproperty
  a_cause_stable: assert property (p_cause_stable)
    else $error("reset cause changed without reset");

endmodule

/* pms_core_model.sv */
`timescale 1ns/10ps

module pms_core_model (
  input wire logic core_clk,
  input wire logic cpu_run,
  input wire logic cmd,
  input wire logic [1:0] cmd_mode,
  output logic sw_req_valid = 1'b0,
  output logic [1:0] sw_req_mode = 2'h0
);
  // ----------------------------------------
  // software mode requests
  // ----------------------------------------
  // a request leaves the core only while it executes code
  always @(negedge core_clk) begin
    if (cmd && cpu_run === 1'b1) begin
      sw_req_valid <= 1'b1;
      sw_req_mode <= cmd_mode;
    end else begin
      sw_req_valid <= 1'b0;
      // mode means nothing without valid, so keep it moving
      sw_req_mode <= ~sw_req_mode;
    end
  end
endmodule

/* tb_power_mode_sequencer.sv */
`timescale 1ns/10ps
`include "pms_consts.svh"

module tb_power_mode_sequencer;
  localparam int SW = 10;
  logic core_clk = 1'b0, resetn = 1'b0, irq_pending = 1'b0;
  logic rtc_event = 1'b0, reset_pin_n = 1'b1, slow_xtal_present = 1'b0;
  logic cmd = 1'b0, chk_en = 1'b0, free = 1'b1, lat_prev = 1'b0;
  logic run_prev = 1'b0;
  logic [1:0] cmd_mode = 2'h0;
  logic [`PMS_NUM_PADS-1:0] wake_pin = '0, wake_pin_en = '0;
  logic [`PMS_NUM_PADS-1:0] gpio_out = '0, held = '0;
  logic [`PMS_NUM_SRAM-1:0] sram_retain_cfg = 4'h5;
  logic sw_req_valid, cpu_run, cpu_clk_en, mem_clk_en, periph_clk_en;
  logic main_power_en, always_on_domain_en, periph_retain, pad_latch;
  logic core_reset, fast_clk_doubler_en, slow_internal_oscillator_sel;
  logic [1:0] sw_req_mode, reset_cause;
  logic [4:0] power_state;
  logic [`PMS_NUM_SRAM-1:0] sram_retain;
  logic [`PMS_NUM_PADS-1:0] pad_out;
  logic [6:0] st_bits;
  logic [31:0] rnd = 32'h2641_4b9f;
  int errors = 0, compares = 0, cyc = 0, ev = 0;
  int lo_q[$], hi_q[$];

  assign st_bits = {cpu_clk_en, mem_clk_en, periph_clk_en, main_power_en,
                    fast_clk_doubler_en, always_on_domain_en, pad_latch};

  pms_core_model core (.core_clk(core_clk), .cpu_run(cpu_run), .cmd(cmd),
    .cmd_mode(cmd_mode), .sw_req_valid(sw_req_valid),
    .sw_req_mode(sw_req_mode));

  pms_sequencer #(.SHDN_WAKE_CYC(SW)) uut (.core_clk(core_clk),
    .resetn(resetn), .sw_req_valid(sw_req_valid),
    .sw_req_mode(sw_req_mode), .irq_pending(irq_pending),
    .rtc_event(rtc_event), .reset_pin_n(reset_pin_n),
    .wake_pin(wake_pin), .wake_pin_en(wake_pin_en), .gpio_out(gpio_out),
    .sram_retain_cfg(sram_retain_cfg),
    .slow_xtal_present(slow_xtal_present), .power_state(power_state),
    .cpu_run(cpu_run), .cpu_clk_en(cpu_clk_en), .mem_clk_en(mem_clk_en),
    .periph_clk_en(periph_clk_en), .main_power_en(main_power_en),
    .always_on_domain_en(always_on_domain_en),
    .periph_retain(periph_retain), .sram_retain(sram_retain),
    .pad_latch(pad_latch), .pad_out(pad_out), .core_reset(core_reset),
    .reset_cause(reset_cause), .fast_clk_doubler_en(fast_clk_doubler_en),
    .slow_internal_oscillator_sel(slow_internal_oscillator_sel));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic finish_test();
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // expected wake latency window, counted from the next edge
  task automatic note(input int lo, input int hi);
    lo_q.push_back(lo);
    hi_q.push_back(hi);
    ev = cyc + 1;
  endtask

  task automatic wait_run();
    int i;
    i = 0;
    while (cpu_run !== 1'b1 && i < 4000) begin
      step(1);
      i++;
    end
    chk(cpu_run, 1'b1);
    step(1);
  endtask

  // pads stay still around entry so the frozen value is unambiguous
  task automatic req(input logic [1:0] m);
    free = 1'b0;
    step(2);
    cmd <= 1'b1;
    cmd_mode <= m;
    step(1);
    cmd <= 1'b0;
    step(2);
    free = 1'b1;
  endtask

  // ----------------------------------------
  // clock, watchdog and monitors
  // ----------------------------------------
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    #1_000_000;
    chk(32'h0, 32'h1);
    finish_test();
  end

  always @(posedge core_clk) cyc <= cyc + 1;

  always @(negedge core_clk) begin
    int d;
    d = cyc - ev;
    if (cpu_run === 1'b1 && run_prev !== 1'b1) begin
      if (lo_q.size() == 0) begin
        chk(32'h0, 32'h1);
      end else begin
        chk(d, (d >= lo_q[0] && d <= hi_q[0]) ? d : lo_q[0]);
        void'(lo_q.pop_front());
        void'(hi_q.pop_front());
      end
    end
    run_prev = cpu_run;
  end

  always @(negedge core_clk) begin
    if (chk_en && resetn) begin
      if (lat_prev === 1'b0 && pad_latch === 1'b0) chk(pad_out, gpio_out);
      if (lat_prev === 1'b1 && pad_latch === 1'b1) chk(pad_out, held);
    end
    lat_prev = pad_latch;
    if (pad_latch !== 1'b1) held = gpio_out;
    if (free) begin
      rnd = lfsr(rnd);
      gpio_out = rnd[30:0];
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rnd = lfsr(rnd);
    wake_pin_en = (rnd[30:0] | 31'h0000_0001) & 31'h7fff_fffd;
    step(1);
    chk(st_bits, 7'h0e);
    chk({power_state, core_reset, reset_cause}, 8'h85);
    step(4);
    resetn = 1'b1;
    note(SW - 2, SW - 1);
    wait_run();
    chk_en = 1'b1;
    chk(power_state, 5'h01);
    chk({st_bits, sram_retain, core_reset}, 12'hfde);
    irq_pending = 1'b1;
    req(2'h0);
    step(20);
    chk(power_state, 5'h01);
    irq_pending = 1'b0;
    for (int i = 0; i < 2; i++) begin
      slow_xtal_present = i[0];
      step(2);
      chk(slow_internal_oscillator_sel, i == 0);
    end
    req(2'h1);
    chk({power_state, st_bits}, 12'h11e);
    step(5);
    irq_pending = 1'b1;
    note(`PMS_IDLE_WAKE_CYC - 1, `PMS_IDLE_WAKE_CYC);
    wait_run();
    irq_pending = 1'b0;
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      sram_retain_cfg = rnd[3:0];
      req(2'h2);
      chk({power_state, st_bits}, 12'h203);
      chk(sram_retain, sram_retain_cfg);
      irq_pending = 1'b1;
      wake_pin[1] = ~wake_pin[1];
      step(12);
      irq_pending = 1'b0;
      chk(power_state, 5'h04);
      note(3023, 3025);
      if (k == 0) rtc_event = 1'b1;
      else wake_pin[0] = ~wake_pin[0];
      step(10);
      chk({power_state, core_reset, periph_retain}, 7'h41);
      wait_run();
      rtc_event = 1'b0;
      chk(reset_cause, 2'h1);
    end
    req(2'h3);
    chk({power_state, st_bits, sram_retain}, 16'h4010);
    rtc_event = 1'b1;
    step(12);
    chk(power_state, 5'h08);
    chk_en = 1'b0;
    note(SW + 3, SW + 5);
    wake_pin[0] = ~wake_pin[0];
    step(6);
    chk({core_reset, periph_retain, pad_latch}, 3'h5);
    wait_run();
    rtc_event = 1'b0;
    chk(reset_cause, 2'h3);
    step(2);
    chk_en = 1'b1;
    req(2'h1);
    chk_en = 1'b0;
    reset_pin_n = 1'b0;
    step(8);
    chk({core_reset, reset_cause}, 3'h6);
    note(SW + 2, SW + 4);
    reset_pin_n = 1'b1;
    wait_run();
    chk(reset_cause, 2'h2);
    resetn = 1'b0;
    step(2);
    chk(reset_cause, 2'h1);
    resetn = 1'b1;
    note(SW - 2, SW - 1);
    wait_run();
    chk(lo_q.size(), 0);
    finish_test();
  end
endmodule
